//--- logic/qhp_pkg.sv
// Package: constants for the four-channel UART host port block.
// Assumes: one 20 MHz clock domain; bus inputs already synchronous.
package qhp_pkg;
  localparam int          NUM_CHAN       = 4;
  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 3;
  localparam int          FIFO_DEPTH     = 32;
  localparam int          CNT_W          = 6;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          RESET_MIN_NS   = 40;
  localparam int          RESET_CYCLES   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register offsets within a channel
  localparam logic [2:0]  OFS_DATA       = 3'h0;
  localparam logic [2:0]  OFS_FCTL       = 3'h2;
  localparam logic [2:0]  OFS_MCTL       = 3'h4;
  localparam logic [2:0]  OFS_LSTAT      = 3'h5;
  localparam logic [2:0]  OFS_SCRATCH    = 3'h7;
  // Field positions
  localparam int          FCTL_FIFO_EN   = 0;
  localparam int          FCTL_BLOCK     = 3;
  localparam int          FCTL_RXTRG_LO  = 6;
  localparam int          FCTL_TXTRG_LO  = 4;
  localparam int          MCTL_IRQ_GATE  = 3;
  localparam int          LSTAT_RX_AVAIL = 0;
  localparam int          LSTAT_TX_ROOM  = 5;
  localparam int          LSTAT_TX_EMPTY = 6;
  // Reset values
  localparam logic [7:0]  FCTL_RESET     = 8'h00;
  localparam logic [7:0]  MCTL_RESET     = 8'h00;
  localparam logic [7:0]  SCRATCH_RESET  = 8'hFF;
  // Bus access state
  typedef enum logic [1:0] {
    QHP_IDLE  = 2'b00,
    QHP_READ  = 2'b01,
    QHP_WRITE = 2'b10
  } qhp_bus_state_t;
endpackage

//--- logic/qhp_channel.sv
// Module: one UART channel register set with transmit and receive FIFO levels.
// Assumes: strobes are single-cycle pulses; serial side gives tx drain and rx fill pulses.
`timescale 1ns/1ps
module qhp_channel (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        tx_drain_i,
  input  wire logic        rx_fill_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_timeout_i,
  input  wire logic        irq_style_sel_i,
  output logic             tx_irq_o,
  output logic             rx_irq_o,
  output logic             irq_en_o,
  output logic             rx_ready_n_o,
  output logic             tx_ready_n_o
);
  logic [7:0] fifo_control;
  logic [7:0] modem_control;
  logic [7:0] scratch;
  logic [7:0] rx_mem [qhp_pkg::FIFO_DEPTH];
  logic [4:0] rx_wp;
  logic [4:0] rx_rp;
  logic [5:0] tx_cnt;
  logic [5:0] rx_cnt;
  logic [5:0] next_rx_cnt;
  logic       rx_blk_low;
  logic       fifo_en;
  logic       blk;
  logic [5:0] cap;
  logic [5:0] tx_trg;
  logic [5:0] rx_trg;
  logic       tx_push;
  logic       rx_pop;
  logic       rx_push;
  logic       tx_pull;

  function automatic logic [5:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'h0:    trig_level = 6'h08;
      2'h1:    trig_level = 6'h10;
      2'h2:    trig_level = 6'h18;
      2'h3:    trig_level = 6'h1C;
    endcase
  endfunction

  assign fifo_en = fifo_control[qhp_pkg::FCTL_FIFO_EN];
  assign blk     = fifo_en & fifo_control[qhp_pkg::FCTL_BLOCK];
  assign cap     = fifo_en ? 6'(qhp_pkg::FIFO_DEPTH) : 6'h01;
  assign tx_trg  = trig_level(fifo_control[qhp_pkg::FCTL_TXTRG_LO +: 2]);
  assign rx_trg  = trig_level(fifo_control[qhp_pkg::FCTL_RXTRG_LO +: 2]);
  assign tx_push = wr_i && addr_i == qhp_pkg::OFS_DATA && tx_cnt < cap;
  assign rx_pop  = rd_i && addr_i == qhp_pkg::OFS_DATA && rx_cnt != 6'h00;
  assign rx_push = rx_fill_i && rx_cnt < cap;
  assign tx_pull = tx_drain_i && tx_cnt != 6'h00;
  assign next_rx_cnt = rx_cnt + {5'h00, rx_push} - {5'h00, rx_pop};

  // Control registers
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      fifo_control  <= qhp_pkg::FCTL_RESET;
      modem_control <= qhp_pkg::MCTL_RESET;
      scratch       <= qhp_pkg::SCRATCH_RESET;
    end
    else if (wr_i)
    begin
      if (addr_i == qhp_pkg::OFS_FCTL)
        fifo_control <= wdata_i;
      if (addr_i == qhp_pkg::OFS_MCTL)
        modem_control <= wdata_i;
      if (addr_i == qhp_pkg::OFS_SCRATCH)
        scratch <= wdata_i;
    end
  end

  // Transmit level
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      tx_cnt <= 6'h00;
    else
      tx_cnt <= tx_cnt + {5'h00, tx_push} - {5'h00, tx_pull};
  end

  // Receive FIFO
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rx_wp  <= 5'h00;
      rx_rp  <= 5'h00;
      rx_cnt <= 6'h00;
    end
    else
    begin
      if (rx_push)
      begin
        rx_mem[rx_wp] <= rx_byte_i;
        rx_wp         <= rx_wp + 5'h01;
      end
      if (rx_pop)
        rx_rp <= rx_rp + 5'h01;
      rx_cnt <= next_rx_cnt;
    end
  end

  // Block mode receive ready latch
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      rx_blk_low <= 1'b0;
    else if (next_rx_cnt == 6'h00)
      rx_blk_low <= 1'b0;
    else if (next_rx_cnt >= rx_trg || rx_timeout_i)
      rx_blk_low <= 1'b1;
  end

  // Read data
  always_comb
  begin
    unique case (addr_i)
      qhp_pkg::OFS_DATA:    rdata_o = rx_cnt != 6'h00 ? rx_mem[rx_rp] : 8'h00;
      qhp_pkg::OFS_FCTL:    rdata_o = fifo_control;
      qhp_pkg::OFS_MCTL:    rdata_o = modem_control;
      qhp_pkg::OFS_LSTAT:   rdata_o = {1'b0,
                                       tx_cnt == 6'h00,
                                       tx_cnt < cap,
                                       4'h0, rx_cnt != 6'h00};
      qhp_pkg::OFS_SCRATCH: rdata_o = scratch;
      default:              rdata_o = 8'h00;
    endcase
  end

  // Outputs from this channel only
  always_comb
  begin
    if (!fifo_en)
    begin
      tx_irq_o     = tx_cnt == 6'h00;
      rx_irq_o     = rx_cnt != 6'h00;
      rx_ready_n_o = rx_cnt == 6'h00;
      tx_ready_n_o = tx_cnt != 6'h00;
    end
    else
    begin
      tx_irq_o     = tx_cnt <= tx_trg;
      rx_irq_o     = rx_cnt >= rx_trg;
      if (blk)
      begin
        rx_ready_n_o = !rx_blk_low;
        tx_ready_n_o = tx_cnt == 6'(qhp_pkg::FIFO_DEPTH);
      end
      else
      begin
        rx_ready_n_o = rx_cnt == 6'h00;
        tx_ready_n_o = tx_cnt != 6'h00;
      end
    end
  end

  // Interrupt enable style
  assign irq_en_o = irq_style_sel_i | modem_control[qhp_pkg::MCTL_IRQ_GATE];
endmodule // qhp_channel

//--- logic/qhp_host_port.sv
// Module: host bus port of a four-channel UART, channel select and status pins.
// Assumes: bus pins sampled as synchronous to mclk_i; oscillator feeds baud logic elsewhere.
`timescale 1ns/1ps
// Notes on behaviour
// - Eight data bits, three address lines, read and write strobes.
// - Bus access needs only selects and strobes, not the oscillator.
// - All channels share one data bus; select decides who answers.
// - High reset longer than 40 ns returns every register to default.
// - Four-select mode: each low select enables its own channel.
// - Four-select mode, all selects low: writes go to every channel together.
// - Single-select mode: two address bits pick channel A to D.
// - Channel address bits used only in single-select mode.
// - Each channel has its own independent register set.
// - FIFO on: transmit interrupt low above trigger, high otherwise.
// - FIFO off: receive interrupt high when a byte is held.
// - FIFO on: receive interrupt high above trigger, low below.
// - FIFO off: ready pins follow single holding registers.
// - FIFO on, no block: receive ready low while data present.
// - FIFO on, no block: transmit ready low when FIFO empty.
// - Block: receive ready falls at trigger or timeout, rises when empty.
// - Block: transmit ready low while room remains, high when full.
// - FIFO control bit 3 selects single or block signalling.
// - Line status bits 5 and 6 show room and fully empty.
// - Oscillator feeds only baud generators, not bus logic.
// - Four-select mode: irq style input and modem control bit 3 gate interrupt pins.
module qhp_host_port (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        bus_type_i,
  input  wire logic        chan_a_select_n_i,
  input  wire logic        chan_b_select_n_i,
  input  wire logic        chan_c_select_n_i,
  input  wire logic        chan_d_select_n_i,
  input  wire logic        chan_addr_hi_i,
  input  wire logic        chan_addr_lo_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic        write_strobe_n_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o,
  output logic             data_oe_o,
  input  wire logic        irq_style_sel_i,
  input  wire logic [3:0]  tx_drain_i,
  input  wire logic [3:0]  rx_fill_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic [3:0]  rx_timeout_i,
  output logic      [3:0]  irq_o,
  output logic      [3:0]  irq_oe_o,
  output logic      [3:0]  rx_ready_n_o,
  output logic      [3:0]  tx_ready_n_o
);
  qhp_pkg::qhp_bus_state_t state;
  qhp_pkg::qhp_bus_state_t next_state;
  logic [3:0] sel;
  logic [3:0] sel_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  logic [3:0] wr_p;
  logic [3:0] rd_p;
  logic [7:0] rdata [4];
  logic [3:0] tx_irq;
  logic [3:0] rx_irq;
  logic [3:0] irq_en;

  function automatic logic [3:0] one_hot2(input logic [1:0] v);
    one_hot2 = 4'h1 << v;
  endfunction

  // Channel decode
  always_comb
  begin
    if (bus_type_i)
      sel = ~{chan_d_select_n_i, chan_c_select_n_i, chan_b_select_n_i, chan_a_select_n_i};
    else if (!chan_a_select_n_i)
      sel = one_hot2({chan_addr_hi_i, chan_addr_lo_i});
    else
      sel = 4'h0;
  end

  // Strobe edge detection; access done on strobe deassertion
  always_comb
  begin
    next_state = state;
    unique case (state)
      qhp_pkg::QHP_IDLE:
        if (!write_strobe_n_i && sel != 4'h0)
          next_state = qhp_pkg::QHP_WRITE;
        else if (!read_strobe_n_i && sel != 4'h0)
          next_state = qhp_pkg::QHP_READ;
      qhp_pkg::QHP_READ:
        if (read_strobe_n_i)
          next_state = qhp_pkg::QHP_IDLE;
      qhp_pkg::QHP_WRITE:
        if (write_strobe_n_i)
          next_state = qhp_pkg::QHP_IDLE;
      default:
        next_state = qhp_pkg::QHP_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      state <= qhp_pkg::QHP_IDLE;
    else
      state <= next_state;
  end

  // Capture select, address and data during the strobe
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sel_q   <= 4'h0;
      addr_q  <= 3'h0;
      wdata_q <= 8'h00;
    end
    else if (state == qhp_pkg::QHP_IDLE)
    begin
      sel_q   <= sel;
      addr_q  <= addr_i;
      wdata_q <= data_i;
    end
    else if (state == qhp_pkg::QHP_WRITE && !write_strobe_n_i)
      wdata_q <= data_i;
  end

  // Write to every selected channel, read on strobe end
  assign wr_p = (state == qhp_pkg::QHP_WRITE && write_strobe_n_i) ? sel_q : 4'h0;
  assign rd_p = (state == qhp_pkg::QHP_READ && read_strobe_n_i) ? sel_q : 4'h0;

  genvar gi;
  generate
    for (gi = 0; gi < qhp_pkg::NUM_CHAN; gi++)
    begin : g_chan
      qhp_channel u_chan (
        .mclk_i          (mclk_i),
        .reset_i         (reset_i),
        .wr_i            (wr_p[gi]),
        .rd_i            (rd_p[gi]),
        .addr_i          (addr_q),
        .wdata_i         (wdata_q),
        .rdata_o         (rdata[gi]),
        .tx_drain_i      (tx_drain_i[gi]),
        .rx_fill_i       (rx_fill_i[gi]),
        .rx_byte_i       (rx_byte_i),
        .rx_timeout_i    (rx_timeout_i[gi]),
        .irq_style_sel_i (irq_style_sel_i),
        .tx_irq_o        (tx_irq[gi]),
        .rx_irq_o        (rx_irq[gi]),
        .irq_en_o        (irq_en[gi]),
        .rx_ready_n_o    (rx_ready_n_o[gi]),
        .tx_ready_n_o    (tx_ready_n_o[gi])
      );
    end
  endgenerate

  // Shared read bus; host reads one channel at a time
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      data_o <= 8'h00;
    else
      data_o <= (sel_q[0] ? rdata[0] : 8'h00) | (sel_q[1] ? rdata[1] : 8'h00)
              | (sel_q[2] ? rdata[2] : 8'h00) | (sel_q[3] ? rdata[3] : 8'h00);
  end

  assign data_oe_o = state == qhp_pkg::QHP_READ && !read_strobe_n_i;

  // Interrupt pins, gated in four-select mode
  always_comb
  begin
    for (int i = 0; i < qhp_pkg::NUM_CHAN; i++)
    begin
      irq_o[i]    = tx_irq[i] | rx_irq[i];
      irq_oe_o[i] = !bus_type_i | irq_en[i];
    end
  end
endmodule // qhp_host_port

//--- verification/qhp_host_port_chk.sv
// Checker: select decode, read drive and pin behaviour of the host port.
// Assumes: bound to qhp_host_port; one clock domain.
`timescale 1ns/1ps
module qhp_host_port_chk (
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       bus_type_i,
  input wire logic       chan_a_select_n_i,
  input wire logic       chan_b_select_n_i,
  input wire logic       chan_c_select_n_i,
  input wire logic       chan_d_select_n_i,
  input wire logic       read_strobe_n_i,
  input wire logic       write_strobe_n_i,
  input wire logic       irq_style_sel_i,
  input wire logic [3:0] tx_drain_i,
  input wire logic [3:0] rx_fill_i,
  input wire logic [3:0] rx_timeout_i,
  input wire logic       data_oe_o,
  input wire logic [3:0] irq_o,
  input wire logic [3:0] irq_oe_o,
  input wire logic [3:0] rx_ready_n_o,
  input wire logic [3:0] tx_ready_n_o
);
  wire logic [3:0] sel_n = {chan_d_select_n_i, chan_c_select_n_i,
                            chan_b_select_n_i, chan_a_select_n_i};
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  a_oe_four_sel: assert property (bus_type_i && $countones(~sel_n) == 1
    && !read_strobe_n_i && !$past(read_strobe_n_i) |-> data_oe_o)
    else $error("four-select read not driven");
  a_oe_single_sel: assert property (!bus_type_i && !chan_a_select_n_i
    && !read_strobe_n_i && !$past(read_strobe_n_i) |-> data_oe_o)
    else $error("single-select read not driven");
  a_desel_quiet: assert property (((bus_type_i && &sel_n)
    || (!bus_type_i && chan_a_select_n_i)) && !read_strobe_n_i |-> !data_oe_o)
    else $error("deselected port drives bus");
  a_reset_pins: assert property ($past(reset_i) |-> rx_ready_n_o == 4'hF
    && tx_ready_n_o == 4'h0 && irq_o == 4'hF)
    else $error("pins not at reset state");
  a_irq_oe_on: assert property (!bus_type_i || irq_style_sel_i |-> irq_oe_o == 4'hF)
    else $error("interrupt output not enabled");
  a_reset_oe: assert property ($past(reset_i) && bus_type_i && !irq_style_sel_i
    |-> irq_oe_o == 4'h0)
    else $error("interrupt output enabled after reset");
  a_rx_indep: assert property (rx_fill_i == 4'h1 && rx_timeout_i == 4'h0
    && read_strobe_n_i && $past(read_strobe_n_i) && write_strobe_n_i
    && $past(write_strobe_n_i) |=> $stable(rx_ready_n_o[3:1]))
    else $error("other channel receive ready moved");
  a_tx_hold: assert property (write_strobe_n_i && $past(write_strobe_n_i)
    && tx_drain_i == 4'h0 |=> $stable(tx_ready_n_o))
    else $error("transmit ready moved without cause");
endmodule // qhp_host_port_chk

bind qhp_host_port qhp_host_port_chk qhp_host_port_chk_i (.mclk_i, .reset_i, .bus_type_i,
  .chan_a_select_n_i, .chan_b_select_n_i, .chan_c_select_n_i, .chan_d_select_n_i,
  .read_strobe_n_i, .write_strobe_n_i, .irq_style_sel_i, .tx_drain_i, .rx_fill_i,
  .rx_timeout_i, .data_oe_o, .irq_o, .irq_oe_o, .rx_ready_n_o, .tx_ready_n_o);

//--- verification/qhp_host_bfm.sv
// Model: processor bus master on the host port.
// Assumes: strobe held until seen high again at a clock edge.
`timescale 1ns/1ps
module qhp_host_bfm (
  input  wire logic       mclk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [3:0] sel_n_o,
  output logic      [1:0] chan_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic      [2:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial
  begin
    sel_n_o = 4'hF;
    chan_o = 2'h0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 3'h0;
    wdata_o = 8'h00;
  end
  // One byte access; callers read with several selects low only in single-select mode
  task automatic acc(input logic wr, input logic [3:0] s, input logic [1:0] c,
                     input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk_i);
    sel_n_o <= s;
    chan_o <= c;
    addr_o <= a;
    wdata_o <= d;
    if (wr)
      wr_n_o <= 1'b0;
    else
      rd_n_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    @(posedge mclk_i);
    q = rdata_i;
    sel_n_o <= 4'hF;
    chan_o <= ~c;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge mclk_i);
  endtask
endmodule // qhp_host_bfm

//--- verification/testbench.sv
// Testbench: host port select, registers and ready and interrupt pins.
// Assumes: bus master model in qhp_host_bfm; checker bound to the design.
`timescale 1ns/1ps
module testbench;
  logic       mclk_i, reset_i, bus_type_i, irq_style_sel_i, rd_n, wr_n, data_oe_o;
  logic [1:0] chan;
  logic [2:0] addr;
  logic [3:0] sel_n, tx_drain_i, rx_fill_i, rx_timeout_i;
  logic [3:0] irq_o, irq_oe_o, rx_ready_n_o, tx_ready_n_o;
  logic [7:0] wdata, data_o, rx_byte_i, q;
  int         mismatches, compares;
  qhp_host_port qhp_host_port_i (.mclk_i, .reset_i, .bus_type_i,
    .chan_a_select_n_i(sel_n[0]), .chan_b_select_n_i(sel_n[1]),
    .chan_c_select_n_i(sel_n[2]), .chan_d_select_n_i(sel_n[3]),
    .chan_addr_hi_i(chan[1]), .chan_addr_lo_i(chan[0]), .read_strobe_n_i(rd_n),
    .write_strobe_n_i(wr_n), .addr_i(addr), .data_i(wdata), .data_o, .data_oe_o,
    .irq_style_sel_i, .tx_drain_i, .rx_fill_i, .rx_byte_i, .rx_timeout_i, .irq_o,
    .irq_oe_o, .rx_ready_n_o, .tx_ready_n_o);
  qhp_host_bfm qhp_host_bfm_i (.mclk_i, .rdata_i(data_o), .sel_n_o(sel_n), .chan_o(chan),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [3:0] s, input logic [2:0] a, input logic [7:0] d);
    qhp_host_bfm_i.acc(1'b1, s, 2'h3, a, d, q);
  endtask
  task automatic rd(input logic [3:0] s, input logic [2:0] a, input logic [7:0] e);
    qhp_host_bfm_i.acc(1'b0, s, 2'h3, a, 8'h00, q);
    chk(q, e);
  endtask
  // Kind 0 receive fill, 1 transmit drain, else receive timeout
  task automatic pulse(input int kind, input logic [3:0] m);
    @(posedge mclk_i);
    if (kind == 0)
      rx_fill_i <= m;
    else if (kind == 1)
      tx_drain_i <= m;
    else
      rx_timeout_i <= m;
    @(posedge mclk_i);
    rx_fill_i <= 4'h0;
    tx_drain_i <= 4'h0;
    rx_timeout_i <= 4'h0;
    #1;
  endtask
  task automatic t_sel();
    for (int k = 0; k < 4; k++)
    begin
      rd(~(4'h1 << k), qhp_pkg::OFS_SCRATCH, qhp_pkg::SCRATCH_RESET);
      rd(~(4'h1 << k), qhp_pkg::OFS_MCTL, qhp_pkg::MCTL_RESET);
      wr(~(4'h1 << k), qhp_pkg::OFS_SCRATCH, 8'h10 + 8'(k));
    end
    wr(4'hF, qhp_pkg::OFS_SCRATCH, 8'hEE);
    for (int k = 0; k < 4; k++)
      rd(~(4'h1 << k), qhp_pkg::OFS_SCRATCH, 8'h10 + 8'(k));
    wr(4'h0, qhp_pkg::OFS_SCRATCH, 8'h5A);
    for (int k = 0; k < 4; k++)
      rd(~(4'h1 << k), qhp_pkg::OFS_SCRATCH, 8'h5A);
    @(posedge mclk_i);
    bus_type_i <= 1'b0;
    for (int k = 0; k < 4; k++)
      qhp_host_bfm_i.acc(1'b1, 4'hE, 2'(k), qhp_pkg::OFS_SCRATCH, 8'h20 + 8'(k), q);
    qhp_host_bfm_i.acc(1'b1, 4'h1, 2'h0, qhp_pkg::OFS_SCRATCH, 8'hEE, q);
    qhp_host_bfm_i.acc(1'b0, 4'h1, 2'h0, qhp_pkg::OFS_SCRATCH, 8'h00, q);
    for (int k = 0; k < 4; k++)
    begin
      qhp_host_bfm_i.acc(1'b0, 4'hE, 2'(k), qhp_pkg::OFS_SCRATCH, 8'h00, q);
      chk(q, 8'h20 + 8'(k));
    end
    @(posedge mclk_i);
    bus_type_i <= 1'b1;
    for (int k = 0; k < 4; k++)
      rd(~(4'h1 << k), qhp_pkg::OFS_SCRATCH, 8'h20 + 8'(k));
  endtask
  task automatic t_fifo_off();
    wr(4'hE, qhp_pkg::OFS_DATA, 8'h33);
    pin(tx_ready_n_o[0], 1'b1);
    pin(irq_o[0], 1'b0);
    rd(4'hE, qhp_pkg::OFS_LSTAT, 8'h00);
    pulse(1, 4'h1);
    pin(tx_ready_n_o[0], 1'b0);
    pin(irq_o[0], 1'b1);
    rd(4'hE, qhp_pkg::OFS_LSTAT, 8'h60);
    wr(4'hD, qhp_pkg::OFS_DATA, 8'hAA);
    pulse(0, 4'h2);
    pin(rx_ready_n_o[1], 1'b0);
    pin(irq_o[1], 1'b1);
    rd(4'hD, qhp_pkg::OFS_DATA, 8'hC3);
    pin(rx_ready_n_o[1], 1'b1);
    pin(irq_o[1], 1'b0);
    wr(4'hB, qhp_pkg::OFS_MCTL, 8'h08);
    chk({4'h0, irq_oe_o}, 8'h04);
    @(posedge mclk_i);
    irq_style_sel_i <= 1'b1;
    @(posedge mclk_i);
    chk({4'h0, irq_oe_o}, 8'h0F);
    irq_style_sel_i <= 1'b0;
  endtask
  task automatic t_fifo_on();
    wr(4'hB, qhp_pkg::OFS_FCTL, 8'h09);
    repeat (8) pulse(0, 4'h4);
    pin(rx_ready_n_o[2], 1'b0);
    repeat (7) rd(4'hB, qhp_pkg::OFS_DATA, 8'hC3);
    pin(rx_ready_n_o[2], 1'b0);
    rd(4'hB, qhp_pkg::OFS_DATA, 8'hC3);
    pin(rx_ready_n_o[2], 1'b1);
    repeat (qhp_pkg::FIFO_DEPTH - 1) wr(4'hB, qhp_pkg::OFS_DATA, 8'h11);
    pin(tx_ready_n_o[2], 1'b0);
    wr(4'hB, qhp_pkg::OFS_DATA, 8'h11);
    pin(tx_ready_n_o[2], 1'b1);
    pin(irq_o[2], 1'b0);
    wr(4'h7, qhp_pkg::OFS_FCTL, 8'h09);
    pulse(0, 4'h8);
    pin(rx_ready_n_o[3], 1'b1);
    pulse(2, 4'h8);
    pin(rx_ready_n_o[3], 1'b0);
    wr(4'hE, qhp_pkg::OFS_FCTL, 8'h01);
    pin(tx_ready_n_o[0], 1'b0);
    wr(4'hE, qhp_pkg::OFS_DATA, 8'h44);
    pin(tx_ready_n_o[0], 1'b1);
    pin(irq_o[0], 1'b1);
    pulse(0, 4'h1);
    pin(rx_ready_n_o[0], 1'b0);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    conclude();
  end
  initial
  begin
    reset_i = 1'b1;
    bus_type_i = 1'b1;
    irq_style_sel_i = 1'b0;
    tx_drain_i = 4'h0;
    rx_fill_i = 4'h0;
    rx_timeout_i = 4'h0;
    rx_byte_i = 8'hC3;
    mismatches = 0;
    compares = 0;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_sel();
    t_fifo_off();
    t_fifo_on();
    conclude();
  end
endmodule // testbench
